// ==== verilog/mcpi_top.sv ====
module mcpi_top #(
    parameter int unsigned POS_W = mcpi_pkg::POS_W  // Position counter width
) (
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    input  wire logic [mcpi_pkg::IMG_ADDR_W-1:0]      imgAddr,
    input  wire logic                                 imgWrEn,
    input  wire logic [7:0]                           imgWrData,
    input  wire logic                                 imgRdEn,
    output logic      [7:0]                           imgRdData,
    input  wire logic                                 imgCommit,
    input  wire logic                                 wordAlign,
    input  wire logic                                 compactImage,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        errorEvent,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        warnLevel,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        encStep,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        encUp,
    input  wire logic [POS_W-1:0]                     presetOne,
    input  wire logic [POS_W-1:0]                     presetTwo,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        captureIn,
    input  wire logic [mcpi_pkg::CHANNELS-1:0]        auxIn,
    output logic      [mcpi_pkg::CHANNELS-1:0]        bridgeEnable,
    output logic      [mcpi_pkg::CHANNELS-1:0]        staticMode,
    output logic      [POS_W-1:0]                     dutyOne,
    output logic      [POS_W-1:0]                     dutyTwo
);
    import mcpi_pkg::*;

    // Staging written by the coupler during an exchange
    logic [CHANNELS-1:0][7:0]       cmdStage_q;     // Command bytes being written
    logic [CHANNELS-1:0][POS_W-1:0] outStage_q;     // Outbound words being written

    // Committed image and previous command for edge detection
    logic [CHANNELS-1:0][7:0]       cmd_q;          // Active command bytes
    logic [CHANNELS-1:0][7:0]       cmdPrev_q;      // Command byte of the exchange before
    logic [CHANNELS-1:0][POS_W-1:0] outWord_q;      // Active outbound words
    logic                           commitSeen_q;   // One cycle after a commit

    // Channel state
    logic [CHANNELS-1:0][POS_W-1:0] pos_q;          // Position counters
    logic [CHANNELS-1:0][POS_W-1:0] capVal_q;       // Captured positions
    logic [CHANNELS-1:0]            err_q;          // Sticky error flags
    logic [CHANNELS-1:0]            capValid_q;     // capture_valid
    logic [CHANNELS-1:0]            presetDone_q;   // preset_done

    // Synchronised pins
    logic [CHANNELS-1:0]            capRise;        // Capture pin rising edge
    logic [CHANNELS-1:0]            capFall;        // Capture pin falling edge
    logic [CHANNELS-1:0]            auxLevel;       // Aux pin level

    // Decode and derived values
    mcpi_slot_t                     slot;           // Slot kind of imgAddr
    logic                           slotCh;         // Channel of imgAddr
    logic [CHANNELS-1:0]            procMode;       // Process data mode per channel
    logic [CHANNELS-1:0]            clrEdge;        // Error clear edge this cycle
    logic [CHANNELS-1:0]            presetEdge;     // Preset edge this cycle
    logic [CHANNELS-1:0][7:0]       status;         // Condition bytes
    logic [CHANNELS-1:0][POS_W-1:0] inWord;         // Inbound words
    logic [CHANNELS-1:0][POS_W-1:0] presetVal;      // Preset per channel

    assign presetVal[0] = presetOne;
    assign presetVal[1] = presetTwo;

    // Pin synchronisers, one capture and one aux pin per channel
    for (genvar c = 0; c < CHANNELS; c++) begin : g_pins
        mcpi_pin_sync u_cap (
            .clk       (clk),
            .rst       (rst),
            .pinIn     (captureIn[c]),
            .level     (),
            .risePulse (capRise[c]),
            .fallPulse (capFall[c])
        );
        mcpi_pin_sync u_aux (
            .clk       (clk),
            .rst       (rst),
            .pinIn     (auxIn[c]),
            .level     (auxLevel[c]),
            .risePulse (),
            .fallPulse ()
        );
    end

    // Address decode; alignment only moves the slots
    always_comb begin
        slot   = SLOT_NONE;
        slotCh = 1'b0;
        if (wordAlign) begin
            case (imgAddr)
                OFS_ALIGN_CMD1:        slot = SLOT_BYTE;
                OFS_ALIGN_WRD1:        slot = SLOT_WLO;
                OFS_ALIGN_WRD1 + 3'h1: slot = SLOT_WHI;
                OFS_ALIGN_CMD2: begin
                    slot   = SLOT_BYTE;
                    slotCh = 1'b1;
                end
                OFS_ALIGN_WRD2: begin
                    slot   = SLOT_WLO;
                    slotCh = 1'b1;
                end
                OFS_ALIGN_WRD2 + 3'h1: begin
                    slot   = SLOT_WHI;
                    slotCh = 1'b1;
                end
                default:               slot = SLOT_NONE;
            endcase
        end else begin
            case (imgAddr)
                OFS_PLAIN_CMD1:        slot = SLOT_BYTE;
                OFS_PLAIN_WRD1:        slot = SLOT_WLO;
                OFS_PLAIN_WRD1 + 3'h1: slot = SLOT_WHI;
                OFS_PLAIN_CMD2: begin
                    slot   = SLOT_BYTE;
                    slotCh = 1'b1;
                end
                OFS_PLAIN_WRD2: begin
                    slot   = SLOT_WLO;
                    slotCh = 1'b1;
                end
                OFS_PLAIN_WRD2 + 3'h1: begin
                    slot   = SLOT_WHI;
                    slotCh = 1'b1;
                end
                default:               slot = SLOT_NONE;
            endcase
        end
    end

    // Coupler writes into staging; command bytes accepted in both forms
    always_ff @(posedge clk) begin
        if (rst) begin
            cmdStage_q <= '0;
            outStage_q <= '0;
        end else if (imgWrEn) begin
            case (slot)
                SLOT_BYTE: cmdStage_q[slotCh]       <= imgWrData;
                SLOT_WLO:  outStage_q[slotCh][7:0]  <= imgWrData;
                SLOT_WHI:  outStage_q[slotCh][15:8] <= imgWrData;
                default:   ;                                       // Unmapped write ignored
            endcase
        end
    end

    // Commit at end of exchange; previous byte kept so edges compare
    // whole exchanges, not individual byte writes
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_q        <= '0;
            cmdPrev_q    <= '0;
            outWord_q    <= '0;
            commitSeen_q <= 1'b0;
        end else begin
            commitSeen_q <= imgCommit;
            if (imgCommit) begin
                cmdPrev_q <= cmd_q;
                cmd_q     <= cmdStage_q;
                outWord_q <= outStage_q;
            end
        end
    end

    // Flags count only in process data mode; edges only right after commit
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            procMode[c]   = !cmd_q[c][CB_REGCOMM];
            clrEdge[c]    = commitSeen_q && procMode[c] && cmd_q[c][CB_ERRCLR]
                            && !cmdPrev_q[c][CB_ERRCLR];
            presetEdge[c] = commitSeen_q && procMode[c] && cmd_q[c][CB_PRESET]
                            && !cmdPrev_q[c][CB_PRESET];
        end
    end

    // Error flags: a new error in the clearing cycle wins
    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (errorEvent[c]) begin
                    err_q[c] <= 1'b1;
                end else if (clrEdge[c]) begin
                    err_q[c] <= 1'b0;
                end
            end
        end
    end

    // Position counters, preset has priority over counting
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_q        <= '0;
            presetDone_q <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (presetEdge[c]) begin
                    pos_q[c]        <= presetVal[c];
                    presetDone_q[c] <= 1'b1;
                end else begin
                    if (encStep[c]) begin
                        pos_q[c] <= encUp[c] ? pos_q[c] + 1'b1 : pos_q[c] - 1'b1;
                    end
                    if (!cmd_q[c][CB_PRESET]) begin
                        presetDone_q[c] <= 1'b0;      // Acknowledge drops with the strobe
                    end
                end
            end
        end
    end

    // Capture: rising enable excludes falling capture entirely
    always_ff @(posedge clk) begin
        if (rst) begin
            capVal_q   <= '0;
            capValid_q <= '0;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (procMode[c] && cmd_q[c][CB_RISE]) begin
                    if (capRise[c]) begin
                        capVal_q[c]   <= pos_q[c];
                        capValid_q[c] <= 1'b1;
                    end
                end else if (procMode[c] && cmd_q[c][CB_FALL]) begin
                    if (capFall[c]) begin
                        capVal_q[c]   <= pos_q[c];
                        capValid_q[c] <= 1'b1;
                    end
                end else begin
                    capValid_q[c] <= 1'b0;          // Disarmed: old value no longer valid
                end
            end
        end
    end

    // Condition bytes and inbound words, same layout for each channel
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            status[c]                = 8'h00;
            status[c][SB_REGCOMM]    = cmd_q[c][CB_REGCOMM];
            status[c][SB_ERROR]      = err_q[c];
            status[c][SB_WARN]       = warnLevel[c];
            status[c][SB_READY]      = cmd_q[c][CB_ENABLE] && procMode[c] && !err_q[c];
            status[c][SB_VIEWACK]    = cmd_q[c][CB_VIEW] && capValid_q[c];
            status[c][SB_CAPVALID]   = capValid_q[c];
            status[c][SB_PRESETDONE] = presetDone_q[c];
            status[c][SB_AUX]        = auxLevel[c];
            inWord[c]                = status[c][SB_VIEWACK] ? capVal_q[c] : pos_q[c];
        end
    end

    // Registered read; compact form carries no inbound data
    always_ff @(posedge clk) begin
        if (rst) begin
            imgRdData <= 8'h00;
        end else if (imgRdEn) begin
            if (compactImage) begin
                imgRdData <= 8'h00;
            end else begin
                case (slot)
                    SLOT_BYTE: imgRdData <= status[slotCh];
                    SLOT_WLO:  imgRdData <= inWord[slotCh][7:0];
                    SLOT_WHI:  imgRdData <= inWord[slotCh][15:8];
                    default:   imgRdData <= 8'h00;
                endcase
            end
        end
    end

    // Bridge drive; disabled or faulted channel stays off
    always_ff @(posedge clk) begin
        if (rst) begin
            bridgeEnable <= '0;
            staticMode   <= '0;
            dutyOne      <= WORD_RESET;
            dutyTwo      <= WORD_RESET;
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                bridgeEnable[c] <= status[c][SB_READY];
                staticMode[c]   <= status[c][SB_READY] && cmd_q[c][CB_DECAY];
            end
            dutyOne <= status[0][SB_READY] ? outWord_q[0] : WORD_RESET;
            dutyTwo <= status[1][SB_READY] ? outWord_q[1] : WORD_RESET;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_clrCommit;
        imgCommit && cmdStage_q[0][CB_ERRCLR] && !cmd_q[0][CB_ERRCLR] && !cmd_q[0][CB_REGCOMM]
            && !cmdStage_q[0][CB_REGCOMM];
    endsequence

    property p_errClear;
        s_clrCommit ##1 !errorEvent[0] ##1 !errorEvent[0] |=> !err_q[0];
    endproperty
    a_errClear: assert property (p_errClear) else $error("error not cleared");

    property p_errSet;
        errorEvent[0] |=> err_q[0] ##1 !bridgeEnable[0];
    endproperty
    a_errSet: assert property (p_errSet) else $error("error did not stop bridge");

    property p_preset;
        presetEdge[0] |=> pos_q[0] == $past(presetOne) && presetDone_q[0];
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");

    property p_capRise;
        procMode[0] && cmd_q[0][CB_RISE] && capRise[0] |=> capVal_q[0] == $past(pos_q[0]) && capValid_q[0];
    endproperty
    a_capRise: assert property (p_capRise) else $error("rising capture missed");

    property p_fallBlocked;
        cmd_q[0][CB_RISE] && capFall[0] && !capRise[0] |=> $stable(capVal_q[0]);
    endproperty
    a_fallBlocked: assert property (p_fallBlocked) else $error("falling capture not blocked");

    property p_compactRead;
        imgRdEn && compactImage |=> imgRdData == 8'h00;
    endproperty
    a_compactRead: assert property (p_compactRead) else $error("compact read returned data");

    property p_disabled;
        !cmd_q[0][CB_ENABLE] |=> !bridgeEnable[0] && dutyOne == WORD_RESET;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel driven");

    property p_decay;
        status[0][SB_READY] |=> staticMode[0] == $past(cmd_q[0][CB_DECAY]);
    endproperty
    a_decay: assert property (p_decay) else $error("decay mode wrong");
endmodule : mcpi_top

// ==== verilog/mcpi_pkg.sv ====
package mcpi_pkg;
    // Image geometry
    localparam int unsigned IMG_ADDR_W      = 3;       // Byte address within the image, 0..7
    localparam int unsigned CHANNELS        = 2;       // Motor channels in the image
    localparam int unsigned POS_W           = 16;      // Position and data word width

    // Byte offsets without word alignment
    localparam logic [2:0]  OFS_PLAIN_CMD1  = 3'h0;    // Command / condition byte, channel one
    localparam logic [2:0]  OFS_PLAIN_WRD1  = 3'h1;    // Word, channel one
    localparam logic [2:0]  OFS_PLAIN_CMD2  = 3'h3;    // Command / condition byte, channel two
    localparam logic [2:0]  OFS_PLAIN_WRD2  = 3'h4;    // Word, channel two

    // Byte offsets with word alignment
    localparam logic [2:0]  OFS_ALIGN_CMD1  = 3'h0;
    localparam logic [2:0]  OFS_ALIGN_WRD1  = 3'h2;
    localparam logic [2:0]  OFS_ALIGN_CMD2  = 3'h4;
    localparam logic [2:0]  OFS_ALIGN_WRD2  = 3'h6;

    // Command byte fields
    localparam int unsigned CB_REGCOMM      = 7;       // register_comm_select, 0 = process data mode
    localparam int unsigned CB_ERRCLR       = 6;       // Error clear, rising edge
    localparam int unsigned CB_ENABLE       = 5;       // Channel enable
    localparam int unsigned CB_VIEW         = 4;       // capture_view_select
    localparam int unsigned CB_FALL         = 3;       // falling_capture_enable
    localparam int unsigned CB_RISE         = 2;       // rising_capture_enable
    localparam int unsigned CB_PRESET       = 1;       // position_preset_strobe, rising edge
    localparam int unsigned CB_DECAY        = 0;       // mixed_decay_disable

    // Condition byte fields
    localparam int unsigned SB_REGCOMM      = 7;       // Mode acknowledge
    localparam int unsigned SB_ERROR        = 6;
    localparam int unsigned SB_WARN         = 5;
    localparam int unsigned SB_READY        = 4;
    localparam int unsigned SB_VIEWACK      = 3;       // capture_view_ack
    localparam int unsigned SB_CAPVALID     = 2;       // capture_valid
    localparam int unsigned SB_PRESETDONE   = 1;       // preset_done
    localparam int unsigned SB_AUX          = 0;       // aux_input_one level

    // Reset values
    localparam logic [7:0]  CMD_RESET       = 8'h00;
    localparam logic [15:0] WORD_RESET      = 16'h0000;

    // Kind of image slot an address hits
    typedef enum logic [1:0] {
        SLOT_NONE,
        SLOT_BYTE,
        SLOT_WLO,
        SLOT_WHI
    } mcpi_slot_t;
endpackage : mcpi_pkg

// ==== verilog/mcpi_pin_sync.sv ====
module mcpi_pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      level,
    output logic      risePulse,
    output logic      fallPulse
);
    logic s1_q;  // First stage, read only by second stage
    logic s2_q;  // Second stage
    logic s3_q;  // Third stage

    // Three-flop chain against metastability
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level moves only once the last two stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level     <= 1'b0;
            risePulse <= 1'b0;
            fallPulse <= 1'b0;
        end else begin
            risePulse <= (s2_q == s3_q) && s3_q && !level;
            fallPulse <= (s2_q == s3_q) && !s3_q && level;
            if (s2_q == s3_q) begin
                level <= s3_q;
            end
        end
    end
endmodule : mcpi_pin_sync

// ==== test/mcpi_coupler_model.sv ====
// Coupler side of the cyclic process image: byte writes, byte reads, commit
module mcpi_coupler_model (
    input  wire logic       clk,
    output logic [2:0]      imgAddr,
    output logic            imgWrEn,
    output logic [7:0]      imgWrData,
    output logic            imgRdEn,
    input  wire logic [7:0] imgRdData,
    output logic            imgCommit,
    output logic            wordAlign,
    output logic            compactImage
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        imgAddr      = 3'h0;
        imgWrEn      = 1'b0;
        imgWrData    = 8'h00;
        imgRdEn      = 1'b0;
        imgCommit    = 1'b0;
        wordAlign    = 1'b0;
        compactImage = 1'b0;
    end

    // Byte offset of a channel item in the current layout
    function automatic logic [2:0] ofs(input int ch, input bit word);
        if (wordAlign) begin
            return 3'(ch * 4 + (word ? 2 : 0));
        end
        return 3'(ch * 3 + (word ? 1 : 0));
    endfunction : ofs

    // Coupler layout selection, a level held between exchanges
    task automatic setMode(input logic align, input logic compact);
        @(negedge clk);
        wordAlign    = align;
        compactImage = compact;
    endtask : setMode

    // One byte write, held across one rising edge
    task automatic wrByte(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        imgAddr   = a;
        imgWrData = d;
        imgWrEn   = 1'b1;
        @(negedge clk);
        imgWrEn   = 1'b0;
        imgWrData = ~d; // Released data never shows the old byte
    endtask : wrByte

    // One byte read; data taken after the answering edge
    task automatic rdByte(input logic [2:0] a, output logic [7:0] d);
        @(negedge clk);
        imgAddr = a;
        imgRdEn = 1'b1;
        @(negedge clk);
        imgRdEn = 1'b0;
        d       = imgRdData;
    endtask : rdByte

    // Command byte and word low then high, then commit pulse
    task automatic sendChan(input int ch, input logic [7:0] cmd, input logic [15:0] w);
        wrByte(ofs(ch, 1'b0), cmd);
        wrByte(ofs(ch, 1'b1), w[7:0]);
        wrByte(ofs(ch, 1'b1) + 3'h1, w[15:8]);
        @(negedge clk);
        imgCommit = 1'b1;
        @(negedge clk);
        imgCommit = 1'b0;
    endtask : sendChan

    // Condition byte and inbound word of one channel
    task automatic readChan(input int ch, output logic [7:0] st, output logic [15:0] w);
        rdByte(ofs(ch, 1'b0), st);
        rdByte(ofs(ch, 1'b1), w[7:0]);
        rdByte(ofs(ch, 1'b1) + 3'h1, w[15:8]);
    endtask : readChan
endmodule : mcpi_coupler_model

// ==== test/tb_motor_channel_process_interface.sv ====
module tb_motor_channel_process_interface;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int WATCH_NS = 200000;  // Generous over a run of about five hundred cycles

    logic        clk, rst, imgWrEn, imgRdEn, imgCommit, wordAlign, compactImage;
    logic [2:0]  imgAddr;
    logic [7:0]  imgWrData, imgRdData;
    logic [1:0]  errorEvent, warnLevel, encStep, encUp, captureIn, auxIn, bridgeEnable, staticMode;
    logic [15:0] presetOne, presetTwo, dutyOne, dutyTwo;
    int          fails, testsRun;

    mcpi_top dut_u (.clk, .rst, .imgAddr, .imgWrEn, .imgWrData, .imgRdEn, .imgRdData, .imgCommit,
        .wordAlign, .compactImage, .errorEvent, .warnLevel, .encStep, .encUp, .presetOne, .presetTwo,
        .captureIn, .auxIn, .bridgeEnable, .staticMode, .dutyOne, .dutyTwo);

    mcpi_coupler_model coupler_u (.clk, .imgAddr, .imgWrEn, .imgWrData, .imgRdEn, .imgRdData,
        .imgCommit, .wordAlign, .compactImage);

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Verdict and end of run, shared with the watchdog
    task automatic results();
        if (fails == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkByte

    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkWord

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    // Exchange plus settle time for the commit to take effect
    task automatic drive(input int ch, input logic [7:0] cmd, input logic [15:0] w);
        coupler_u.sendChan(ch, cmd, w);
        idle(3);
    endtask : drive

    // Bridge pins: {static, enable} and outbound duty
    task automatic chkOut(input int ch, input logic [1:0] sb, input logic [15:0] duty);
        chkByte({6'h0, staticMode[ch], bridgeEnable[ch]}, {6'h0, sb});
        chkWord(ch ? dutyTwo : dutyOne, duty);
    endtask : chkOut

    task automatic checkChan(input int ch, input logic [7:0] st, input logic [15:0] w);
        logic [7:0]  s;
        logic [15:0] d;
        coupler_u.readChan(ch, s, d);
        chkByte(s, st);
        chkWord(d, w);
    endtask : checkChan

    // Encoder count pulse, up or down
    task automatic step(input int ch, input logic up);
        encUp[ch]   = up;
        encStep[ch] = 1'b1;
        idle(1);
        encStep[ch] = 1'b0;
        idle(1);
    endtask : step

    // Capture pin change with sync latency allowed
    task automatic pin(input logic v);
        captureIn[0] = v;
        idle(8);
    endtask : pin

    // Both layouts, both channels: enable, decay, aux, warning, mode bit
    task automatic testLayout();
        logic [7:0] s;
        for (int a = 0; a < 2; a++) begin
            for (int ch = 0; ch < 2; ch++) begin
                coupler_u.setMode(a[0], 1'b0);
                auxIn[ch]     = 1'b1;
                warnLevel[ch] = 1'b1;
                drive(ch, 8'h21, 16'h1234 + 16'(ch));
                chkOut(ch, 2'b11, 16'h1234 + 16'(ch));
                checkChan(ch, 8'h31, 16'h0000);
                coupler_u.rdByte(a ? 3'h1 : 3'h7, s);
                chkByte(s, 8'h00);
                drive(ch, 8'ha0, 16'h0000);
                chkOut(ch, 2'b00, 16'h0000);
                auxIn[ch]     = 1'b0;
                warnLevel[ch] = 1'b0;
                drive(ch, 8'h20, 16'h0000);
                checkChan(ch, 8'h10, 16'h0000);
            end
        end
        coupler_u.setMode(1'b0, 1'b0);
    endtask : testLayout

    // Sticky error drops the bridge; rising clear bit restores it
    task automatic testError();
        for (int ch = 0; ch < 2; ch++) begin
            drive(ch, 8'h20, 16'h0055);
            errorEvent[ch] = 1'b1;
            idle(1);
            errorEvent[ch] = 1'b0;
            idle(3);
            chkOut(ch, 2'b00, 16'h0000);
            checkChan(ch, 8'h40, 16'h0000);
            drive(ch, 8'h60, 16'h0042);
            chkOut(ch, 2'b01, 16'h0042);
            drive(ch, 8'h20, 16'h0000);
        end
    endtask : testError

    // Preset load, acknowledge, count on, acknowledge withdrawn
    task automatic testPreset();
        presetOne = 16'h0a50;
        presetTwo = 16'h0a51;
        for (int ch = 0; ch < 2; ch++) begin
            drive(ch, 8'h22, 16'h0000);
            checkChan(ch, 8'h12, 16'h0a50 + 16'(ch));
            step(ch, 1'b1);
            checkChan(ch, 8'h12, 16'h0a51 + 16'(ch));
            drive(ch, 8'h20, 16'h0000);
            checkChan(ch, 8'h10, 16'h0a51 + 16'(ch));
        end
    endtask : testPreset

    // Edge selection and precedence on channel one, position starts at 0a51
    task automatic testCapture();
        drive(0, 8'h28, 16'h0000);
        pin(1'b1);
        checkChan(0, 8'h10, 16'h0a51);
        step(0, 1'b0);
        pin(1'b0);
        step(0, 1'b1);
        drive(0, 8'h38, 16'h0000);
        checkChan(0, 8'h1c, 16'h0a50);
        drive(0, 8'h2c, 16'h0000);
        pin(1'b1);
        step(0, 1'b1);
        pin(1'b0);
        drive(0, 8'h3c, 16'h0000);
        checkChan(0, 8'h1c, 16'h0a51);
        drive(0, 8'h20, 16'h0000);
        checkChan(0, 8'h10, 16'h0a52);
    endtask : testCapture

    // Compact image: commands still act, reads carry nothing
    task automatic testCompact();
        coupler_u.setMode(1'b0, 1'b1);
        drive(1, 8'h21, 16'h0077);
        chkOut(1, 2'b11, 16'h0077);
        checkChan(1, 8'h00, 16'h0000);
        coupler_u.setMode(1'b0, 1'b0);
    endtask : testCompact

    // Reset, then the scenarios in order
    initial begin
        fails      = 0;
        testsRun   = 0;
        rst        = 1'b1;
        errorEvent = 2'h0;
        warnLevel  = 2'h0;
        encStep    = 2'h0;
        encUp      = 2'h0;
        captureIn  = 2'h0;
        auxIn      = 2'h0;
        presetOne  = 16'h0000;
        presetTwo  = 16'h0000;
        idle(13);  // Thirteen rising edges see reset high
        rst = 1'b0;
        idle(1);
        chkByte({4'h0, staticMode, bridgeEnable}, 8'h00);
        testLayout();
        testError();
        testPreset();
        testCapture();
        testCompact();
        results();
    end

    // Hang guard
    initial begin
        #WATCH_NS;
        fails++;
        results();
    end
endmodule : tb_motor_channel_process_interface
